/* File: dac_load_defs.svh */
// Purpose: constants for the dual converter serial load front end
// Assumes: one system clock samples every pin
// Notes: widths and presets used by the control module
// How it works
// RL1: two converter registers, one per channel, fed from one shared shift register
// RL2: select high ignores serial clock edges; select never touches load strobes
// RL3: each serial clock rising edge while selected shifts one bit in, MSB first
// RL4: serial data goes straight into the shift register stage
// RL5: channel A register follows shift register while its load strobe is low
// RL6: channel B register follows shift register while its own strobe is low
// RL7: active-low preset forces both converter registers to a preset value
// RL8: preset with level select high gives half-scale, MSB one
// RL9: preset with level select low clears both registers to zero
// RL10: sleep leaves shift register and converter registers unchanged
// RL11: during sleep shifting and loading work exactly as normal
// RL12: after sleep outputs show the latest converter register value
// RL13: surplus leading bits drop out; only the last resolution bits remain
// RL14: host keeps both strobes high while shifting new data
// RL15: host pulses both strobes together to load both channels alike
// RL16: converter register holds its value once its strobe returns high
`ifndef DAC_LOAD_DEFS_SVH
`define DAC_LOAD_DEFS_SVH
`define DAC_RES_DEFAULT 12
`define DAC_FIFO_DEPTH 16
`define DAC_SYNC_STAGES 2
`define DAC_CODE_RST 0
`define DAC_PIN_IDLE 1'b1
`endif

/* File: dac_load_pkg.sv */
// Purpose: shared types for the serial load front end
// Assumes: nothing beyond the defs header
// Notes: constants live in dac_load_defs.svh
package dac_load_pkg;
  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_A,
    LOAD_B,
    LOAD_AB
  } load_sel_t;
endpackage

/* File: dac_load_properties.sv */
// Purpose: port checker for the serial load front end
// Assumes: pin to code latency of four clk edges
// Notes: bound into the design top
`timescale 1ns/1ps
module dac_load_properties #(
  parameter int RES = 12
) (
  // clock, reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins
  input wire logic load_a_n,
  input wire logic load_b_n,
  input wire logic preset_n,
  input wire logic preset_mid,
  input wire logic sleep_n,
  // outputs
  input wire logic [RES-1:0] code_a,
  input wire logic [RES-1:0] code_b,
  input wire logic awake
);
  localparam logic [RES-1:0] HALF = {1'b1, {(RES-1){1'b0}}};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_HOLD_A:
    assert property ((load_a_n && preset_n)[*6] |=> $stable(code_a)) else $error("code_a moved");
  AST_HOLD_B:
    assert property ((load_b_n && preset_n)[*6] |=> $stable(code_b)) else $error("code_b moved");
  AST_BOTH:
    assert property ((!load_a_n && !load_b_n && preset_n)[*6] |-> code_a == code_b) else $error("codes differ");
  AST_MID:
    assert property ((!preset_n && preset_mid)[*6] |-> code_a == HALF && code_b == HALF) else $error("not half");
  AST_ZERO:
    assert property ((!preset_n && !preset_mid)[*6] |-> code_a == '0 && code_b == '0) else $error("not zero");
  AST_AWAKE:
    assert property ((sleep_n && !sys_rst)[*4] |-> awake) else $error("awake low");
  AST_ASLEEP:
    assert property ((!sleep_n)[*4] |-> !awake) else $error("awake high");
  AST_SLEEP_KEEP:
    assert property ((load_a_n && preset_n)[*6] ##0 $changed(awake) |-> $stable(code_a)) else $error("sleep moved");
endmodule
bind dual_dac_serial_load_control dac_load_properties #(.RES(RES)) props (.clk(clk), .sys_rst(sys_rst),
  .load_a_n(load_a_n), .load_b_n(load_b_n), .preset_n(preset_n), .preset_mid(preset_mid),
  .sleep_n(sleep_n), .code_a(code_a), .code_b(code_b), .awake(awake));

/* File: dual_dac_serial_load_control.sv */
// Purpose: serial shift register and two converter registers of a dual converter
// Assumes: host pins asynchronous; clk well above serial clock rate
// Notes: strobes sampled, so transparency lags pins by the sync delay
`timescale 1ns/1ps
`include "dac_load_defs.svh"
module dual_dac_serial_load_control
  import dac_load_pkg::*;
#(
  parameter int RES = `DAC_RES_DEFAULT,
  parameter int FIFO_DEPTH = `DAC_FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // serial link pins
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  // load and control pins
  input wire logic load_a_n,
  input wire logic load_b_n,
  input wire logic preset_n,
  input wire logic preset_mid,
  input wire logic sleep_n,
  // converter codes and awake flag
  output logic [RES-1:0] code_a,
  output logic [RES-1:0] code_b,
  output logic awake,
  // shifted word stream
  output logic word_valid,
  input wire logic word_ready,
  output logic [RES-1:0] word_data,
  output logic word_overflow
);
  localparam int CW = $clog2(RES + 1);
  localparam logic [CW-1:0] BITS_FULL = CW'(RES);
  localparam int NPIN = 8;
  localparam logic [RES-1:0] CODE_RST = RES'(`DAC_CODE_RST);
  localparam logic [NPIN-1:0] PIN_IDLE = {NPIN{`DAC_PIN_IDLE}};

  // synchronised pin group, preset level strap included
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins_s;
  logic mid_s;
  logic sel_s;
  logic sclk_s;
  logic data_s;
  logic strobe_a_s;
  logic strobe_b_s;
  logic preset_s;
  logic sleep_s;
  // edge history
  logic sclk_prev_reg;
  logic sclk_prev_next;
  logic sel_prev_reg;
  logic sel_prev_next;
  logic shift_edge;
  logic frame_end;
  // shift and converter registers
  logic [RES-1:0] shift_reg;
  logic [RES-1:0] shift_next;
  logic [RES-1:0] dac_a_reg;
  logic [RES-1:0] dac_a_next;
  logic [RES-1:0] dac_b_reg;
  logic [RES-1:0] dac_b_next;
  load_sel_t load_sel;
  logic load_a;
  logic load_b;
  // output stage
  logic [RES-1:0] code_a_next;
  logic [RES-1:0] code_b_next;
  logic awake_next;
  // per-frame word capture
  logic [CW-1:0] bits_reg;
  logic [CW-1:0] bits_next;
  logic bits_full;
  logic word_done;
  logic wv_reg;
  logic wv_next;
  logic [RES-1:0] wd_reg;
  logic [RES-1:0] wd_next;
  logic ovf_reg;
  logic ovf_next;
  // fifo and stream output
  logic f_valid;
  logic [RES-1:0] f_data;
  logic f_in_ready;
  logic f_out_ready;
  logic word_valid_hold;
  logic word_valid_next;
  logic [RES-1:0] word_data_next;
  logic word_overflow_next;

  function automatic logic [RES-1:0] preset_code(input logic mid);
    preset_code = mid ? {1'b1, {(RES-1){1'b0}}} : '0; // RL8 RL9
  endfunction

  // true when the strobe pattern copies into the given channel
  function automatic logic strobe_hits(input load_sel_t sel, input load_sel_t chan);
    strobe_hits = (sel == chan) || (sel == LOAD_AB);
  endfunction

  assign pins_raw = {preset_mid, select_n, serial_clk, serial_in, load_a_n, load_b_n, preset_n, sleep_n};
  pin_sync #(.W(NPIN)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .d(pins_raw),
    .rst_val(PIN_IDLE),
    .q(pins_s)
  );

  assign mid_s = pins_s[7];
  assign sel_s = pins_s[6];
  assign sclk_s = pins_s[5];
  assign data_s = pins_s[4];
  assign strobe_a_s = pins_s[3];
  assign strobe_b_s = pins_s[2];
  assign preset_s = pins_s[1];
  assign sleep_s = pins_s[0];

  // rising serial clock edge while selected; sleep does not gate it
  assign shift_edge = !sel_s && sclk_s && !sclk_prev_reg; // RL2 RL3 RL11
  assign frame_end = sel_s && !sel_prev_reg;
  assign sclk_prev_next = sclk_s;
  assign sel_prev_next = sel_s;
  // data bit enters lsb, older bits move toward msb and fall off
  assign shift_next = shift_edge ? {shift_reg[RES-2:0], data_s} : shift_reg; // RL1 RL3 RL4 RL10 RL13

  assign load_sel = load_sel_t'({!strobe_b_s, !strobe_a_s}); // RL2
  assign load_a = strobe_hits(load_sel, LOAD_A); // RL5 RL15
  assign load_b = strobe_hits(load_sel, LOAD_B); // RL6 RL15
  // preset dominates, then transparent load, else hold
  assign dac_a_next = !preset_s ? preset_code(mid_s) : (load_a ? shift_reg : dac_a_reg); // RL5 RL7 RL11 RL16
  assign dac_b_next = !preset_s ? preset_code(mid_s) : (load_b ? shift_reg : dac_b_reg); // RL6 RL7 RL11 RL16

  // outputs keep tracking registers in sleep; only awake shows it
  assign code_a_next = dac_a_reg; // RL12
  assign code_b_next = dac_b_reg; // RL12
  assign awake_next = sleep_s; // RL10

  // one word per frame that shifted at least one bit
  assign bits_full = (bits_reg == BITS_FULL);
  assign bits_next = frame_end ? '0 : ((shift_edge && !bits_full) ? bits_reg + 1'b1 : bits_reg);
  assign word_done = frame_end && (bits_reg != '0);
  assign wv_next = word_done;
  assign wd_next = word_done ? shift_reg : wd_reg;
  assign ovf_next = ovf_reg || (word_done && !f_in_ready);

  // output word stands until taken; fifo pops only into a free slot
  assign word_valid_hold = word_valid && !word_ready;
  assign f_out_ready = !word_valid_hold;
  assign word_valid_next = word_valid_hold ? word_valid : f_valid;
  assign word_data_next = word_valid_hold ? word_data : f_data;
  assign word_overflow_next = ovf_reg;

  // frame words queue here until the consumer takes them
  word_fifo #(.WIDTH(RES), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(wv_reg),
    .in_ready(f_in_ready),
    .in_data(wd_reg),
    .out_valid(f_valid),
    .out_ready(f_out_ready),
    .out_data(f_data)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_reg <= 1'b1;
    end else begin
      if (ce) begin
        sclk_prev_reg <= sclk_prev_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_prev_reg <= 1'b1;
    end else begin
      if (ce) begin
        sel_prev_reg <= sel_prev_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= '0;
    end else begin
      if (ce) begin
        shift_reg <= shift_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_a_reg <= CODE_RST;
    end else begin
      if (ce) begin
        dac_a_reg <= dac_a_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_b_reg <= CODE_RST;
    end else begin
      if (ce) begin
        dac_b_reg <= dac_b_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_a <= CODE_RST;
    end else begin
      if (ce) begin
        code_a <= code_a_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_b <= CODE_RST;
    end else begin
      if (ce) begin
        code_b <= code_b_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awake <= 1'b0;
    end else begin
      if (ce) begin
        awake <= awake_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bits_reg <= '0;
    end else begin
      if (ce) begin
        bits_reg <= bits_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wv_reg <= 1'b0;
    end else begin
      if (ce) begin
        wv_reg <= wv_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_reg <= '0;
    end else begin
      if (ce) begin
        wd_reg <= wd_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_reg <= 1'b0;
    end else begin
      if (ce) begin
        ovf_reg <= ovf_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_valid <= 1'b0;
    end else begin
      if (ce) begin
        word_valid <= word_valid_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_data <= '0;
    end else begin
      if (ce) begin
        word_data <= word_data_next;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_overflow <= 1'b0;
    end else begin
      if (ce) begin
        word_overflow <= word_overflow_next;
      end
    end
  end
endmodule

/* File: host_model.sv */
// Purpose: host side of the link: select, serial clock, data, strobes
// Assumes: clk is the bench clock
// Notes: serial clock 320 ns, stands low outside frames
`timescale 1ns/1ps
module host_model (
  // bench clock
  input wire logic clk,
  // link pins
  output logic select_n = 1'b1,
  output logic serial_clk = 1'b0,
  output logic serial_in = 1'b0,
  // strobes
  output logic load_a_n = 1'b1,
  output logic load_b_n = 1'b1
);
  task automatic frame(input logic [15:0] w, input int n, input logic sel);
    select_n <= sel;
    repeat (4) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= w[i];
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    select_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (4) @(posedge clk);
  endtask
  task automatic load(input logic a, input logic b);
    load_a_n <= !a;
    load_b_n <= !b;
    repeat (4) @(posedge clk);
    load_a_n <= 1'b1;
    load_b_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

/* File: pin_sync.sv */
// Purpose: two-flop synchroniser for a group of pins
// Assumes: inputs asynchronous to clk
// Notes: first stage read only by the second
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // pins
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '1;
      q <= '1;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the serial load front end
// Assumes: host model drives the link pins
// Notes: integer model of shift and converter registers
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic preset_n = 1'b1;
  logic preset_mid = 1'b0;
  logic sleep_n = 1'b1;
  logic word_ready = 1'b0;
  logic ce = 1'b1;
  logic ovf = 1'b0;
  logic select_n, serial_clk, serial_in, load_a_n, load_b_n, awake, word_valid, word_overflow;
  logic [11:0] code_a, code_b, word_data;
  int errors = 0, n_checks = 0, cycles = 0, sr = 0, ca = 0, cb = 0, w;
  int q[$];
  always #20 clk = ~clk;
  host_model host (.clk(clk), .select_n(select_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .load_a_n(load_a_n), .load_b_n(load_b_n));
  dual_dac_serial_load_control dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .select_n(select_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .load_a_n(load_a_n), .load_b_n(load_b_n),
    .preset_n(preset_n), .preset_mid(preset_mid), .sleep_n(sleep_n), .code_a(code_a), .code_b(code_b),
    .awake(awake), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .word_overflow(word_overflow));
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input int exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp[11:0]) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp[11:0], got);
    end
  endtask
  task automatic send(input int v, input int n, input logic sel);
    if (!sel) begin
      for (int i = n - 1; i >= 0; i--) sr = ((sr << 1) | ((v >> i) & 1)) & 'hfff;
      q.push_back(sr);
    end
    host.frame(v[15:0], n, sel);
  endtask
  task automatic ld(input logic a, input logic b);
    host.load(a, b);
    if (a) ca = sr;
    if (b) cb = sr;
    chk("code_a", ca, code_a);
    chk("code_b", cb, code_b);
  endtask
  always @(posedge clk) begin
    word_ready <= ovf ? 1'b0 : 1'($urandom % 2);
    cycles <= cycles + 1;
    if (word_valid === 1'b1 && word_ready === 1'b1 && !ovf) chk("word_data", q.size() ? q.pop_front() : -1, word_data);
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    w = $urandom(70);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      send($urandom, 12, 1'b0);
      ld(k != 1, k != 0);
    end
    send($urandom, 16, 1'b0);
    ld(1'b1, 1'b1);
    send($urandom, 12, 1'b1);
    ld(1'b1, 1'b0);
    sleep_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("awake", 0, awake);
    send($urandom, 12, 1'b0);
    ld(1'b0, 1'b1);
    sleep_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("awake", 1, awake);
    chk("code_b", cb, code_b);
    for (int m = 1; m >= 0; m--) begin
      preset_mid <= m[0];
      @(posedge clk);
      preset_n <= 1'b0;
      repeat (8) @(posedge clk);
      preset_n <= 1'b1;
      repeat (6) @(posedge clk);
      ca = m ? 'h800 : 0;
      cb = ca;
      chk("code_a", ca, code_a);
      chk("code_b", ca, code_b);
    end
    repeat (60) @(posedge clk);
    chk("pending", 0, q.size());
    // strobes pulsed while the clock enable is low must not reach the codes
    ce <= 1'b0;
    host.load(1'b1, 1'b1);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk("code_a", ca, code_a);
    chk("code_b", cb, code_b);
    ovf <= 1'b1;
    repeat (20) host.frame(16'h0001, 1, 1'b0);
    chk("word_overflow", 1, word_overflow);
    results();
  end
endmodule

/* File: word_fifo.sv */
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock
// Notes: depth a power of two
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  wire push = ce && in_valid && !full;
  wire pop = ce && out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_reg[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule
